// >>> design/adc_dma_pkg.sv
/*
 * Shared constants, types and state encoding of the ADC DMA sequencer
 * for its first mode.
 * Assumes one system clock and a synchronous active-high reset.
 */
package adc_dma_pkg;

    localparam int INSTR_W        = 8;
    localparam int IADDR_W        = 8;
    localparam int DADDR_W        = 16;
    localparam int RESULT_W       = 16;
    localparam int FIFO_DEPTH     = 16;

    // Instruction word fields; a word with neither converter bit ends a pass
    localparam int INSTR_ADC0_BIT = 4;
    localparam int INSTR_ADC1_BIT = 5;
    localparam int INSTR_CONT_BIT = 7;

    localparam logic [2:0] STEP_BYTES_ONE = 3'h2;
    localparam logic [2:0] STEP_BYTES_TWO = 3'h4;

    localparam logic [15:0] REPEAT_DONE   = 16'h0000;
    localparam logic [15:0] REPEAT_ONE    = 16'h0001;
    localparam logic [15:0] DADDR_RESET   = 16'h0000;
    localparam logic [7:0]  IADDR_RESET   = 8'h00;
    localparam logic [7:0]  INSTR_RESET   = 8'h00;

    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic [7:0]         data;
    } mem_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_DECODE,
        ST_WAIT_ADC,
        ST_WRITE
    } seq_state_t;

endpackage

// >>> design/adc_dma_seq.sv
/*
 * ADC DMA sequencer for the first mode, with its write FIFO.
 * Assumes a synchronous instruction buffer with one cycle of read
 * latency, converters that hold valid until acknowledged and drop it
 * after the acknowledge, and a data memory port with a ready input.
 */
`timescale 1ns/1ps

module adc_dma_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("adc_dma_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Extra pointer bit tells a full ring from an empty one
    assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                   (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign push  = i_in_valid && !full;
    assign pop   = i_out_ready && !empty;

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule

module adc_dma_seq #(
    parameter int FIFO_DEPTH = adc_dma_pkg::FIFO_DEPTH
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_START,
    input  wire logic [7:0]  I_DATA_ADDR_BEGIN_HIGH,
    input  wire logic [7:0]  I_DATA_ADDR_BEGIN_LOW,
    input  wire logic [7:0]  I_INSTR_BOUNDARY_ADDR,
    input  wire logic [7:0]  I_REPEAT_LIMIT_HIGH,
    input  wire logic [7:0]  I_REPEAT_LIMIT_LOW,
    output logic      [7:0]  O_IBUF_ADDR,
    input  wire logic [7:0]  I_IBUF_DATA,
    input  wire logic        I_ADC0_VALID,
    input  wire logic [15:0] I_ADC0_DATA,
    output logic             O_ADC0_ACK,
    input  wire logic        I_ADC1_VALID,
    input  wire logic [15:0] I_ADC1_DATA,
    output logic             O_ADC1_ACK,
    output logic             O_MEM_WE,
    output logic      [15:0] O_MEM_ADDR,
    output logic      [7:0]  O_MEM_DATA,
    input  wire logic        I_MEM_READY,
    output logic             O_BUSY,
    output logic      [7:0]  O_CURRENT_INSTR_ADDR,
    output logic      [7:0]  O_REPEAT_COUNT_HIGH,
    output logic      [7:0]  O_REPEAT_COUNT_LOW,
    output logic      [15:0] O_DATA_ADDR
);
    generate
        if (FIFO_DEPTH < 4) begin : g_bad_fifo
            $error("adc_dma_seq: FIFO_DEPTH must hold one full step");
        end
    endgenerate

    adc_dma_pkg::seq_state_t state_r;
    adc_dma_pkg::seq_state_t state_nxt;
    adc_dma_pkg::mem_wr_t    push_word;
    adc_dma_pkg::mem_wr_t    pop_word;

    logic [7:0]  isw_r;
    logic [7:0]  instr_r;
    logic [15:0] ptr_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_dec;
    logic [15:0] res0_r;
    logic [15:0] res1_r;
    logic [1:0]  idx_r;
    logic [2:0]  nbytes;
    logic        use0;
    logic        use1;
    logic        is_end;
    logic        adc_ok;
    logic        take;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic        push_done;
    logic        last_byte;
    logic        ack0_r;
    logic        ack1_r;
    logic        we_r;
    logic [15:0] maddr_r;
    logic [7:0]  mdata_r;
    logic [7:0]  byte_sel;
    logic        busy_r;

    assign use0    = instr_r[adc_dma_pkg::INSTR_ADC0_BIT];
    assign use1    = instr_r[adc_dma_pkg::INSTR_ADC1_BIT];
    assign is_end  = !use0 && !use1;
    assign nbytes  = (use0 && use1) ? adc_dma_pkg::STEP_BYTES_TWO
                                    : adc_dma_pkg::STEP_BYTES_ONE;
    assign cnt_dec = cnt_r - 16'h0001;

    // Wait for every converter the step names, none more
    assign adc_ok  = (!use0 || I_ADC0_VALID) && (!use1 || I_ADC1_VALID);
    assign take    = (state_r == adc_dma_pkg::ST_WAIT_ADC) && adc_ok;

    // Byte order: first result high, low, then second result high, low
    always_comb begin
        byte_sel = 8'h00;
        case (idx_r)
            2'h0:    byte_sel = use0 ? res0_r[15:8] : res1_r[15:8];
            2'h1:    byte_sel = use0 ? res0_r[7:0]  : res1_r[7:0];
            2'h2:    byte_sel = res1_r[15:8];
            2'h3:    byte_sel = res1_r[7:0];
            default: byte_sel = 8'h00;
        endcase
    end

    assign fifo_in_valid  = (state_r == adc_dma_pkg::ST_WRITE);
    assign push_done      = fifo_in_valid && fifo_in_ready;
    assign last_byte      = ({1'b0, idx_r} == (nbytes - 3'h1));
    assign push_word.addr = ptr_r + {14'h0000, idx_r};
    assign push_word.data = byte_sel;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc_dma_pkg::ST_IDLE: begin
                if (I_START) begin
                    state_nxt = adc_dma_pkg::ST_FETCH;
                end
            end
            adc_dma_pkg::ST_FETCH: begin
                state_nxt = adc_dma_pkg::ST_DECODE;
            end
            adc_dma_pkg::ST_DECODE: begin
                state_nxt = adc_dma_pkg::ST_WAIT_ADC;
            end
            adc_dma_pkg::ST_WAIT_ADC: begin
                if (is_end) begin
                    if (instr_r[adc_dma_pkg::INSTR_CONT_BIT]) begin
                        state_nxt = adc_dma_pkg::ST_FETCH;
                    end else if (cnt_r <= adc_dma_pkg::REPEAT_ONE) begin
                        state_nxt = adc_dma_pkg::ST_IDLE;
                    end else begin
                        state_nxt = adc_dma_pkg::ST_FETCH;
                    end
                end else if (adc_ok) begin
                    state_nxt = adc_dma_pkg::ST_WRITE;
                end
            end
            adc_dma_pkg::ST_WRITE: begin
                if (push_done && last_byte) begin
                    state_nxt = adc_dma_pkg::ST_FETCH;
                end
            end
            default: state_nxt = adc_dma_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_r <= adc_dma_pkg::ST_IDLE;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r  <= (state_nxt != adc_dma_pkg::ST_IDLE);
        end
    end

    // Current instruction address, which also addresses the buffer
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            isw_r <= adc_dma_pkg::IADDR_RESET;
        end else if (state_r == adc_dma_pkg::ST_IDLE && I_START) begin
            isw_r <= I_INSTR_BOUNDARY_ADDR;
        end else if (state_r == adc_dma_pkg::ST_WAIT_ADC && is_end) begin
            isw_r <= I_INSTR_BOUNDARY_ADDR;
        end else if (push_done && last_byte) begin
            isw_r <= isw_r + 8'h01;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            instr_r <= adc_dma_pkg::INSTR_RESET;
        end else if (state_r == adc_dma_pkg::ST_DECODE) begin
            instr_r <= I_IBUF_DATA;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ptr_r <= adc_dma_pkg::DADDR_RESET;
        end else if (state_r == adc_dma_pkg::ST_IDLE && I_START) begin
            ptr_r <= {I_DATA_ADDR_BEGIN_HIGH, I_DATA_ADDR_BEGIN_LOW};
        end else if (push_done && last_byte) begin
            ptr_r <= ptr_r + {13'h0000, nbytes};
        end
    end

    // Continuous passes leave the counter untouched
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            cnt_r <= adc_dma_pkg::REPEAT_DONE;
        end else if (state_r == adc_dma_pkg::ST_IDLE && I_START) begin
            cnt_r <= {I_REPEAT_LIMIT_HIGH, I_REPEAT_LIMIT_LOW};
        end else if (state_r == adc_dma_pkg::ST_WAIT_ADC && is_end &&
                     !instr_r[adc_dma_pkg::INSTR_CONT_BIT] &&
                     cnt_r != adc_dma_pkg::REPEAT_DONE) begin
            cnt_r <= cnt_dec;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            res0_r <= 16'h0000;
            res1_r <= 16'h0000;
        end else if (take) begin
            res0_r <= I_ADC0_DATA;
            res1_r <= I_ADC1_DATA;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ack0_r <= 1'b0;
            ack1_r <= 1'b0;
        end else begin
            ack0_r <= take && !is_end && use0;
            ack1_r <= take && !is_end && use1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            idx_r <= 2'h0;
        end else if (take) begin
            idx_r <= 2'h0;
        end else if (push_done) begin
            idx_r <= idx_r + 2'h1;
        end
    end

    // A full FIFO holds the sequencer in its write state
    adc_dma_fifo #(
        .WIDTH ($bits(adc_dma_pkg::mem_wr_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_REF_CLK),
        .i_rst       (I_RST),
        .i_in_valid  (fifo_in_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_word),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (pop_word)
    );

    // Output stage holds a write until memory takes it
    assign fifo_out_ready = !we_r || I_MEM_READY;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            we_r    <= 1'b0;
            maddr_r <= adc_dma_pkg::DADDR_RESET;
            mdata_r <= 8'h00;
        end else if (fifo_out_ready) begin
            we_r <= fifo_out_valid;
            if (fifo_out_valid) begin
                maddr_r <= pop_word.addr;
                mdata_r <= pop_word.data;
            end
        end
    end

    assign O_IBUF_ADDR          = isw_r;
    assign O_CURRENT_INSTR_ADDR = isw_r;
    assign O_ADC0_ACK           = ack0_r;
    assign O_ADC1_ACK           = ack1_r;
    assign O_MEM_WE             = we_r;
    assign O_MEM_ADDR           = maddr_r;
    assign O_MEM_DATA           = mdata_r;
    assign O_BUSY               = busy_r;
    assign O_REPEAT_COUNT_HIGH  = cnt_r[15:8];
    assign O_REPEAT_COUNT_LOW   = cnt_r[7:0];
    assign O_DATA_ADDR          = ptr_r;

endmodule

// >>> dv/adc_dma_partner.sv
/* Far side model: instruction buffer, two converters, memory port.
   The bench writes the program into prog before each start. */
`timescale 1ns/1ps
module adc_dma_partner (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_ibuf_addr,
    output logic      [7:0]  o_ibuf_data,
    input  wire logic        i_ack0,
    input  wire logic        i_ack1,
    output logic             o_valid0,
    output logic             o_valid1,
    output logic      [15:0] o_data0,
    output logic      [15:0] o_data1,
    output logic             o_mem_ready
);
    logic [7:0]  prog [256];
    logic [15:0] n0;
    logic [15:0] n1;
    initial foreach (prog[i]) prog[i] = 8'h00;
    // Outside valid the bus shows the inverse so stale data cannot pass
    assign o_data0 = o_valid0 ? 16'hA000 + n0 : ~(16'hA000 + n0);
    assign o_data1 = o_valid1 ? 16'h5000 + n1 : ~(16'h5000 + n1);
    always_ff @(posedge i_clk) o_ibuf_data <= prog[i_ibuf_addr];
    always_ff @(posedge i_clk) o_mem_ready <= ($urandom % 3) != 0;
    // Valid holds until ack and drops right after it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid0 <= 1'b0;
            n0 <= 16'h0000;
        end else if (i_ack0) begin
            o_valid0 <= 1'b0;
            n0 <= n0 + 16'h0001;
        end else if ($urandom % 4 == 0) o_valid0 <= 1'b1;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid1 <= 1'b0;
            n1 <= 16'h0000;
        end else if (i_ack1) begin
            o_valid1 <= 1'b0;
            n1 <= n1 + 16'h0001;
        end else if ($urandom % 3 == 0) o_valid1 <= 1'b1;
    end
endmodule

// >>> dv/adc_dma_seq_asserts.sv
/* Port checker for the ADC DMA sequencer.
   Bound to every adc_dma_seq; sees only its top ports. */
`timescale 1ns/1ps
module adc_dma_seq_asserts (
    input wire logic        I_REF_CLK,
    input wire logic        I_RST,
    input wire logic        I_START,
    input wire logic [7:0]  I_DATA_ADDR_BEGIN_HIGH,
    input wire logic [7:0]  I_DATA_ADDR_BEGIN_LOW,
    input wire logic [7:0]  I_INSTR_BOUNDARY_ADDR,
    input wire logic [7:0]  I_REPEAT_LIMIT_HIGH,
    input wire logic [7:0]  I_REPEAT_LIMIT_LOW,
    input wire logic        I_ADC0_VALID,
    input wire logic        O_ADC0_ACK,
    input wire logic        I_ADC1_VALID,
    input wire logic        O_ADC1_ACK,
    input wire logic        O_MEM_WE,
    input wire logic [15:0] O_MEM_ADDR,
    input wire logic [7:0]  O_MEM_DATA,
    input wire logic        I_MEM_READY,
    input wire logic        O_BUSY,
    input wire logic [7:0]  O_CURRENT_INSTR_ADDR,
    input wire logic [7:0]  O_REPEAT_COUNT_HIGH,
    input wire logic [7:0]  O_REPEAT_COUNT_LOW,
    input wire logic [15:0] O_DATA_ADDR
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    wire [15:0] cnt = {O_REPEAT_COUNT_HIGH, O_REPEAT_COUNT_LOW};
    wire [15:0] ptr = O_DATA_ADDR;
    wire [7:0]  ia  = O_CURRENT_INSTR_ADDR;

    a_start_loads: assert property (
        I_START && !O_BUSY |=> O_BUSY
        && ptr == $past({I_DATA_ADDR_BEGIN_HIGH, I_DATA_ADDR_BEGIN_LOW})
        && ia == $past(I_INSTR_BOUNDARY_ADDR)
        && cnt == $past({I_REPEAT_LIMIT_HIGH, I_REPEAT_LIMIT_LOW}))
        else $error("start load wrong");
    a_ptr_step: assert property (
        O_BUSY && $past(O_BUSY) && $changed(ptr)
        |-> (ptr - $past(ptr)) inside {16'h0002, 16'h0004})
        else $error("pointer step wrong");
    a_iaddr_step: assert property (
        O_BUSY && $past(O_BUSY) && $changed(ia)
        |-> ia == $past(ia) + 8'h01 || ia == I_INSTR_BOUNDARY_ADDR)
        else $error("instruction address step wrong");
    a_count_dec: assert property (
        O_BUSY && $past(O_BUSY) && $changed(cnt)
        |-> cnt == $past(cnt) - 16'h0001)
        else $error("repeat counter step wrong");
    a_idle_zero: assert property (
        $fell(O_BUSY) |-> cnt == 16'h0000)
        else $error("idle with counter left");
    a_ack0_pulse: assert property (
        O_ADC0_ACK |-> $past(I_ADC0_VALID) && O_BUSY ##1 !O_ADC0_ACK)
        else $error("converter 0 ack wrong");
    a_ack1_pulse: assert property (
        O_ADC1_ACK |-> $past(I_ADC1_VALID) && O_BUSY ##1 !O_ADC1_ACK)
        else $error("converter 1 ack wrong");
    a_mem_hold: assert property (
        O_MEM_WE && !I_MEM_READY |=> O_MEM_WE
        && $stable(O_MEM_ADDR) && $stable(O_MEM_DATA))
        else $error("write dropped before ready");
endmodule

bind adc_dma_seq adc_dma_seq_asserts u_chk (.*);

// >>> dv/adc_dma_seq_bench.sv
/* Self-checking bench for the ADC DMA sequencer.
   Uses adc_dma_partner as far side; the checker is bound. */
`timescale 1ns/1ps
module adc_dma_seq_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [7:0]  dah = 8'h00, dal = 8'h00, bnd = 8'h00;
    logic [7:0]  rlh = 8'h00, rll = 8'h00;
    logic [7:0]  ia, id, cia, rch, rcl, mdata;
    logic        v0, v1, a0, a1, we, rdy, busy;
    logic [15:0] d0, d1, maddr, dptr;
    int          err_count = 0, cmp_count = 0, cyc = 0, e0 = 0, e1 = 0;
    logic [23:0] expq[$], gotq[$];
    logic [7:0]  w [8];

    always #5 clk = ~clk;
    adc_dma_seq u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_START(start),
        .I_DATA_ADDR_BEGIN_HIGH(dah), .I_DATA_ADDR_BEGIN_LOW(dal),
        .I_INSTR_BOUNDARY_ADDR(bnd), .I_REPEAT_LIMIT_HIGH(rlh),
        .I_REPEAT_LIMIT_LOW(rll), .O_IBUF_ADDR(ia), .I_IBUF_DATA(id),
        .I_ADC0_VALID(v0), .I_ADC0_DATA(d0), .O_ADC0_ACK(a0),
        .I_ADC1_VALID(v1), .I_ADC1_DATA(d1), .O_ADC1_ACK(a1),
        .O_MEM_WE(we), .O_MEM_ADDR(maddr), .O_MEM_DATA(mdata),
        .I_MEM_READY(rdy), .O_BUSY(busy), .O_CURRENT_INSTR_ADDR(cia),
        .O_REPEAT_COUNT_HIGH(rch), .O_REPEAT_COUNT_LOW(rcl),
        .O_DATA_ADDR(dptr));
    adc_dma_partner u_part (.i_clk(clk), .i_rst(rst), .i_ibuf_addr(ia),
        .o_ibuf_data(id), .i_ack0(a0), .i_ack1(a1), .o_valid0(v0),
        .o_valid1(v1), .o_data0(d0), .o_data1(d1), .o_mem_ready(rdy));

    task chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        if (we && rdy && !rst) gotq.push_back({maddr, mdata});
        if (++cyc > 30000) begin
            err_count++;
            summarize();
        end
    end
    task push(input logic [15:0] a, input logic [15:0] v);
        expq.push_back({a, v[15:8]});
        expq.push_back({a + 16'h0001, v[7:0]});
    endtask
    task cycle;
        @(posedge clk);
        #1;
    endtask

    task run(input logic [7:0] b, input logic [15:0] ba,
             input logic [15:0] lim, input int nw);
        logic [15:0] p, k;
        p = ba;
        for (int i = 0; i < nw; i++) u_part.prog[b + i] = w[i];
        cycle();
        {dah, dal} = ba;
        bnd = b;
        {rlh, rll} = lim;
        start = 1'b1;
        cycle();
        start = 1'b0;
        for (int n = 0; n < ((lim == 0) ? 1 : lim); n++)
            for (int i = 0; i < nw - 1; i++) begin
                k = 16'h0000;
                if (w[i][4]) begin
                    push(p, 16'hA000 + e0[15:0]);
                    e0++;
                    k = 16'h0002;
                end
                if (w[i][5]) begin
                    push(p + k, 16'h5000 + e1[15:0]);
                    e1++;
                    k += 16'h0002;
                end
                p += k;
            end
        // A second start while running must change nothing
        repeat (3) cycle();
        {dah, dal} = ~ba;
        start = 1'b1;
        cycle();
        start = 1'b0;
        while (busy) cycle();
        for (int t = 0; t < 100 && gotq.size() < expq.size(); t++) cycle();
        chk(gotq.size(), expq.size());
        foreach (expq[i]) chk(gotq[i], expq[i]);
        chk(dptr, p);
        chk({rch, rcl}, 0);
        chk(cia, b);
        expq.delete();
        gotq.delete();
    endtask

    initial begin
        void'($urandom(32'h73d4));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        chk({busy, dptr, cia, rch, rcl}, 0);
        // Pointer wraps past the top of memory over three passes
        w[0] = 8'h30;
        w[1] = 8'h10;
        w[2] = 8'h00;
        run(8'hFC, 16'hFFF8, 16'h0003, 3);
        // A limit of zero still runs one pass
        w[0] = 8'h20;
        w[1] = 8'h4F;
        run(8'h10, 16'h0100, 16'h0000, 2);
        for (int r = 0; r < 6; r++) begin
            int nw;
            nw = 2 + $urandom % 5;
            for (int i = 0; i < nw - 1; i++)
                w[i] = 8'((1 + $urandom % 3) * 16 + $urandom % 16);
            w[nw - 1] = 8'($urandom) & 8'h4F;
            run(8'($urandom % 200), 16'($urandom), 16'($urandom % 4), nw);
        end
        // Continuous flag: passes go past the limit, counter holds
        u_part.prog[0] = 8'h10;
        u_part.prog[1] = 8'h80;
        cycle();
        {dah, dal} = 16'h0000;
        bnd = 8'h00;
        {rlh, rll} = 16'h0002;
        start = 1'b1;
        cycle();
        start = 1'b0;
        for (int t = 0; t < 2000 && gotq.size() < 12; t++) cycle();
        chk({busy, rch, rcl}, {1'b1, 16'h0002});
        chk(gotq[11], {16'h000B, 8'(e0 + 5)});
        // Only a reset stops a continuous run
        rst = 1'b1;
        repeat (2) cycle();
        rst = 1'b0;
        e0 = 0;
        e1 = 0;
        gotq.delete();
        chk({busy, dptr, cia, rch, rcl}, 0);
        w[0] = 8'h30;
        w[1] = 8'h00;
        run(8'h05, 16'h1234, 16'h0001, 2);
        summarize();
    end
endmodule
